// [shared/ipm_cfg.svh]
`ifndef IPM_CFG_SVH
`define IPM_CFG_SVH
// register addresses on the special function register bus
`define IPM_ADDR_PWR 8'h87
`define IPM_ADDR_LVLA 8'hB8
`define IPM_ADDR_LVLB 8'hB9
`define IPM_PWR_RESET 8'h00
`define IPM_LVL_RESET 8'h00
// power control field positions
`define IPM_BIT_BAUD 7
`define IPM_BIT_AUX 6
`define IPM_BIT_QUIET 5
`define IPM_BIT_WDLOAD 4
`define IPM_BIT_PDOWN 1
`define IPM_BIT_IDLE 0
// 12 clocks per machine cycle, watchdog restart after 3 machine cycles
`define IPM_MC_CLKS 4'd12
`define IPM_WD_RESTART_MC 2'd3
`define IPM_VEC_BASE 16'h0003
`define IPM_VEC_STEP 16'h0008
`define IPM_NSRC 15
`endif

// [shared/ipm_pkg.sv]
package ipm_pkg;
    // source index = vector slot (vector = base + 8 * index)
    typedef enum logic [3:0] {
        IPM_SRC_EXTA = 4'b0000, IPM_SRC_TMRA = 4'b0001,
        IPM_SRC_EXTB = 4'b0010, IPM_SRC_TMRB = 4'b0011,
        IPM_SRC_UART = 4'b0100, IPM_SRC_TWOW = 4'b0101,
        IPM_SRC_CAPA = 4'b0110, IPM_SRC_CAPB = 4'b0111,
        IPM_SRC_CAPC = 4'b1000, IPM_SRC_CAPD = 4'b1001,
        IPM_SRC_CONV = 4'b1010, IPM_SRC_CMPA = 4'b1011,
        IPM_SRC_CMPB = 4'b1100, IPM_SRC_CMPC = 4'b1101,
        IPM_SRC_T2OV = 4'b1110
    } ipm_src_e;
    typedef enum logic [1:0] {
        IPM_RUN = 2'b00,
        IPM_IDLE = 2'b01,
        IPM_PDOWN = 2'b10
    } ipm_mode_e;
endpackage

// [verilog/ipm_level_pick.sv]
`timescale 1ns/1ps
// fixed polling order inside one priority level
module ipm_level_pick (
    input wire logic [14:0] req,
    output logic hit,
    output ipm_pkg::ipm_src_e src
);
    import ipm_pkg::*;
    // polling order, highest first
    localparam ipm_src_e ORDER [15] = '{IPM_SRC_EXTA, IPM_SRC_TWOW,
        IPM_SRC_CONV, IPM_SRC_TMRA, IPM_SRC_CAPA, IPM_SRC_CMPA,
        IPM_SRC_EXTB, IPM_SRC_CAPB, IPM_SRC_CMPB, IPM_SRC_TMRB,
        IPM_SRC_CAPC, IPM_SRC_CMPC, IPM_SRC_UART, IPM_SRC_CAPD,
        IPM_SRC_T2OV};
    always_comb begin
        hit = 1'b0;
        src = IPM_SRC_EXTA;
        // scan from lowest so the highest overwrites last
        for (int i = 14; i >= 0; i--) begin
            if (req[ORDER[i]]) begin // RQ4
                hit = 1'b1;
                src = ORDER[i];
            end
        end
    end
endmodule

// [verilog/ipm_mc_timer.sv]
`timescale 1ns/1ps
`include "ipm_cfg.svh"
// machine cycle strobe: one pulse every 12 clocks
module ipm_mc_timer (
    input wire logic ref_clk,
    input wire logic rst,
    output logic mc_tick
);
    logic [3:0] cnt_reg;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg == `IPM_MC_CLKS - 4'd1) begin
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= cnt_reg + 4'd1;
        end
    end
    assign mc_tick = (cnt_reg == `IPM_MC_CLKS - 4'd1);
endmodule

// [verilog/ipm_core.sv]
`timescale 1ns/1ps
`include "ipm_cfg.svh"
// What this block does
// RQ1 - enable bit 0 masks a source, 1 lets it request
// RQ2 - level register a: bit per source, bit 7 reserved reads zero
// RQ3 - level register b: timer 2 overflow, compares, captures
// RQ4 - equal level requests granted in fixed polling order
// RQ5 - vectors from 0003H in steps of eight up to 0073H
// RQ6 - baud doubling bit drives the uart doubling output
// RQ7 - aux memory disable bit routes data moves external
// RQ8 - interference bit stops latch enable toggling, clears on reset
// RQ9 - software sets load enable; cleared when watchdog is loaded
// RQ10 - power-down bit settable only while watchdog enable input high
// RQ11 - idle bit write halts cpu after that instruction, state kept
// RQ12 - idle stops timer 2, pwm high, aborts conversion, rest runs
// RQ13 - power-down halts clock; slow osc runs only if pll and keep bit
// RQ14 - pin states: idle strobes high, power-down low, pwm high
// RQ15 - in idle two-wire pins drive only when port enabled
// RQ16 - power control at 87H, resets to zero, not bit addressable
// RQ17 - enabled wake source clears idle unless equal/higher in service
// RQ18 - external reset ends idle; hold times are the far side's
// RQ19 - watchdog reset ends idle, restart three machine cycles later
// RQ20 - power-down refused with watchdog on; registers kept in it
// RQ21 - power-down wake on enabled level-sensitive external/seconds
// RQ22 - wake with equal/higher in service goes to idle instead
// RQ23 - high pre-empts low; nothing pre-empts high; high first
// RQ24 - return clears the active level flag set at acknowledge
// RQ25 - seconds flag ored with external 1 when its enable set
// RQ26 - one winner per machine cycle by level then polling order
module ipm_core (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic [14:0] irq_flags,
    input wire logic [14:0] irq_enables,
    input wire logic global_enable,
    input wire logic seconds_flag,
    input wire logic seconds_irq_enable,
    input wire logic ext_b_level_mode,
    input wire logic ext_a_level_mode,
    input wire logic ack,
    input wire logic reti,
    input wire logic watchdog_loaded,
    input wire logic watchdog_reset,
    input wire logic watchdog_enable_input_n,
    input wire logic oscillator_source_select,
    input wire logic keep_slow_osc_running,
    input wire logic twowire_port_enable,
    input wire logic ext_memory,
    output logic irq_valid,
    output logic [15:0] irq_vector,
    output logic baud_double_bit,
    output logic aux_memory_disable,
    output logic latch_toggle_enable,
    output logic watchdog_load_enable,
    output logic cpu_halt,
    output logic sysclk_run,
    output logic slow_osc_run,
    output logic idle_block_reset,
    output logic strobe_level,
    output logic strobe_override,
    output logic port0_float,
    output logic port2_addr_drive,
    output logic twowire_pins_allow,
    output logic pwm_force_high,
    output logic cpu_restart
);
    import ipm_pkg::*;

    logic [7:0] pwr_reg;
    logic [6:0] lvla_reg;
    logic [7:0] lvlb_reg;
    logic [1:0] active_reg;
    ipm_mode_e mode_reg;
    logic [1:0] wd_cnt_reg;
    logic wd_pend_reg;
    logic mc_tick;
    logic [14:0] req;
    logic [14:0] lvl;
    logic [14:0] hi_req;
    logic [14:0] lo_req;
    logic hi_hit;
    logic lo_hit;
    ipm_src_e hi_src;
    ipm_src_e lo_src;
    logic win_hi;
    logic win_ok;
    ipm_src_e win_src;
    logic wake_any;
    logic wake_lvl;
    logic wake_blocked;
    logic idle_wake;

    ipm_mc_timer u_mc (
        .ref_clk(ref_clk),
        .rst(rst),
        .mc_tick(mc_tick)
    );

    // level per source index
    always_comb begin
        lvl = 15'h0000;
        lvl[IPM_SRC_EXTA] = lvla_reg[0]; // RQ2
        lvl[IPM_SRC_TMRA] = lvla_reg[1];
        lvl[IPM_SRC_EXTB] = lvla_reg[2];
        lvl[IPM_SRC_TMRB] = lvla_reg[3];
        lvl[IPM_SRC_UART] = lvla_reg[4];
        lvl[IPM_SRC_TWOW] = lvla_reg[5];
        lvl[IPM_SRC_CONV] = lvla_reg[6];
        lvl[IPM_SRC_CAPA] = lvlb_reg[0]; // RQ3
        lvl[IPM_SRC_CAPB] = lvlb_reg[1];
        lvl[IPM_SRC_CAPC] = lvlb_reg[2];
        lvl[IPM_SRC_CAPD] = lvlb_reg[3];
        lvl[IPM_SRC_CMPA] = lvlb_reg[4];
        lvl[IPM_SRC_CMPB] = lvlb_reg[5];
        lvl[IPM_SRC_CMPC] = lvlb_reg[6];
        lvl[IPM_SRC_T2OV] = lvlb_reg[7];
    end

    always_comb begin
        req = irq_flags & irq_enables & {15{global_enable}}; // RQ1
        req[IPM_SRC_EXTB] = (irq_flags[IPM_SRC_EXTB]
            | (seconds_flag & seconds_irq_enable)) // RQ25
            & irq_enables[IPM_SRC_EXTB] & global_enable;
    end

    // high requests only if no high handler runs; low only if idle level
    assign hi_req = active_reg[1] ? 15'h0000 : (req & lvl); // RQ23
    assign lo_req = (active_reg != 2'b00) ? 15'h0000 : (req & ~lvl);

    ipm_level_pick u_hi (
        .req(hi_req),
        .hit(hi_hit),
        .src(hi_src)
    );
    ipm_level_pick u_lo (
        .req(lo_req),
        .hit(lo_hit),
        .src(lo_src)
    );

    assign win_hi = hi_hit; // RQ23
    assign win_ok = hi_hit | lo_hit;
    assign win_src = hi_hit ? hi_src : lo_src;

    // slots 0 to 5 are the sources still clocked in idle
    assign idle_wake = |((hi_req | lo_req) & 15'h003f); // RQ17

    // power-down wake: only level-sensitive external inputs
    assign wake_any = (req[IPM_SRC_EXTA] & ext_a_level_mode)
        | (req[IPM_SRC_EXTB] & ext_b_level_mode); // RQ21
    assign wake_lvl = (req[IPM_SRC_EXTA] & ext_a_level_mode
        & lvl[IPM_SRC_EXTA]) | (req[IPM_SRC_EXTB] & ext_b_level_mode
        & lvl[IPM_SRC_EXTB]);
    assign wake_blocked = active_reg[1] | (active_reg[0] & ~wake_lvl);

    // vector presented once per machine cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_valid <= 1'b0;
            irq_vector <= `IPM_VEC_BASE;
        end else if (mc_tick) begin
            irq_valid <= win_ok & (mode_reg != IPM_PDOWN); // RQ26
            irq_vector <= `IPM_VEC_BASE
                + {9'h000, win_src, 3'b000}; // RQ5
        end
    end

    // active level flags: set on ack, return clears the top one
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            active_reg <= 2'b00;
        end else if (ack & irq_valid) begin
            if (win_hi) begin
                active_reg[1] <= 1'b1;
            end else begin
                active_reg[0] <= 1'b1;
            end
        end else if (reti) begin
            if (active_reg[1]) begin // RQ24
                active_reg[1] <= 1'b0;
            end else begin
                active_reg[0] <= 1'b0;
            end
        end
    end

    // register writes; reset clears everything
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lvla_reg <= 7'h00;
            lvlb_reg <= `IPM_LVL_RESET;
        end else if (sfr_wr && sfr_addr == `IPM_ADDR_LVLA) begin
            lvla_reg <= sfr_wdata[6:0];
        end else if (sfr_wr && sfr_addr == `IPM_ADDR_LVLB) begin
            lvlb_reg <= sfr_wdata;
        end
    end

    // whole-byte access only, no bit addressing
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pwr_reg <= `IPM_PWR_RESET; // RQ16 RQ8
        end else begin
            if (sfr_wr && sfr_addr == `IPM_ADDR_PWR) begin
                pwr_reg[7:5] <= sfr_wdata[7:5];
                pwr_reg[3:2] <= sfr_wdata[3:2];
                pwr_reg[`IPM_BIT_IDLE] <= sfr_wdata[`IPM_BIT_IDLE]; // RQ11
                // refused while the watchdog is enabled
                pwr_reg[`IPM_BIT_PDOWN] <= sfr_wdata[`IPM_BIT_PDOWN]
                    & watchdog_enable_input_n; // RQ10 RQ20
                // a load in the same cycle wins over a software set
                pwr_reg[`IPM_BIT_WDLOAD] <= sfr_wdata[`IPM_BIT_WDLOAD]
                    & ~watchdog_loaded; // RQ9
            end else if (watchdog_loaded) begin
                pwr_reg[`IPM_BIT_WDLOAD] <= 1'b0; // RQ9
            end
            // a watchdog reset must not fall straight back into idle
            if (watchdog_reset
                || (mode_reg == IPM_IDLE && idle_wake && mc_tick)) begin
                pwr_reg[`IPM_BIT_IDLE] <= 1'b0; // RQ17 RQ19
            end
            if (mode_reg == IPM_PDOWN && wake_any) begin
                pwr_reg[`IPM_BIT_PDOWN] <= 1'b0; // RQ21
                pwr_reg[`IPM_BIT_IDLE] <= wake_blocked; // RQ22
            end
        end
    end

    // mode follows the bits; registers are untouched on wake
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_reg <= IPM_RUN; // RQ18
        end else begin
            unique case (mode_reg)
                IPM_RUN: begin
                    if (pwr_reg[`IPM_BIT_PDOWN]) begin
                        mode_reg <= IPM_PDOWN; // RQ13
                    end else if (pwr_reg[`IPM_BIT_IDLE]) begin
                        mode_reg <= IPM_IDLE; // RQ11
                    end
                end
                IPM_IDLE: begin
                    if (watchdog_reset) begin
                        mode_reg <= IPM_RUN; // RQ19
                    end else if (!pwr_reg[`IPM_BIT_IDLE]) begin
                        mode_reg <= IPM_RUN; // RQ17
                    end
                end
                IPM_PDOWN: begin
                    if (wake_any) begin
                        mode_reg <= wake_blocked ? IPM_IDLE : IPM_RUN;
                    end
                end
                default: mode_reg <= IPM_RUN;
            endcase
        end
    end

    // restart pulse three machine cycles after watchdog reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wd_pend_reg <= 1'b0;
            wd_cnt_reg <= 2'd0;
            cpu_restart <= 1'b0;
        end else begin
            cpu_restart <= 1'b0;
            if (watchdog_reset) begin
                wd_pend_reg <= 1'b1;
                wd_cnt_reg <= 2'd0;
            end else if (wd_pend_reg && mc_tick) begin
                if (wd_cnt_reg == `IPM_WD_RESTART_MC - 2'd1) begin
                    wd_pend_reg <= 1'b0;
                    cpu_restart <= 1'b1; // RQ19
                end else begin
                    wd_cnt_reg <= wd_cnt_reg + 2'd1;
                end
            end
        end
    end

    // pin and block controls, registered so outputs leave flops
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            baud_double_bit <= 1'b0;
            aux_memory_disable <= 1'b0;
            latch_toggle_enable <= 1'b1;
            watchdog_load_enable <= 1'b0;
            cpu_halt <= 1'b0;
            sysclk_run <= 1'b1;
            slow_osc_run <= 1'b0;
            idle_block_reset <= 1'b0;
            strobe_level <= 1'b1;
            strobe_override <= 1'b0;
            port0_float <= 1'b0;
            port2_addr_drive <= 1'b0;
            twowire_pins_allow <= 1'b1;
            pwm_force_high <= 1'b0;
            sfr_rdata <= 8'h00;
        end else begin
            baud_double_bit <= pwr_reg[`IPM_BIT_BAUD]; // RQ6
            aux_memory_disable <= pwr_reg[`IPM_BIT_AUX]; // RQ7
            latch_toggle_enable <= ~pwr_reg[`IPM_BIT_QUIET]; // RQ8
            watchdog_load_enable <= pwr_reg[`IPM_BIT_WDLOAD];
            cpu_halt <= (mode_reg != IPM_RUN); // RQ11
            sysclk_run <= (mode_reg != IPM_PDOWN); // RQ13
            slow_osc_run <= (mode_reg != IPM_PDOWN)
                ? ~oscillator_source_select
                : (~oscillator_source_select
                & keep_slow_osc_running); // RQ13
            idle_block_reset <= (mode_reg == IPM_IDLE); // RQ12
            pwm_force_high <= (mode_reg != IPM_RUN); // RQ12 RQ14
            strobe_override <= (mode_reg != IPM_RUN); // RQ14
            strobe_level <= (mode_reg != IPM_PDOWN); // RQ14
            port0_float <= (mode_reg != IPM_RUN) & ext_memory;
            port2_addr_drive <= (mode_reg == IPM_IDLE) & ext_memory;
            unique case (mode_reg)
                IPM_IDLE: twowire_pins_allow <= twowire_port_enable; // RQ15
                IPM_PDOWN: twowire_pins_allow <= 1'b0; // RQ14
                default: twowire_pins_allow <= 1'b1;
            endcase
            if (sfr_rd && sfr_addr == `IPM_ADDR_PWR) begin
                sfr_rdata <= pwr_reg;
            end else if (sfr_rd && sfr_addr == `IPM_ADDR_LVLA) begin
                sfr_rdata <= {1'b0, lvla_reg};
            end else if (sfr_rd && sfr_addr == `IPM_ADDR_LVLB) begin
                sfr_rdata <= lvlb_reg;
            end else begin
                sfr_rdata <= 8'h00;
            end
        end
    end

    // power-down bit never set while the watchdog input is low
    chk_pd_refused: assert property (@(posedge ref_clk) disable iff (rst)
        (sfr_wr && sfr_addr == `IPM_ADDR_PWR && !watchdog_enable_input_n
        && !pwr_reg[`IPM_BIT_PDOWN]) |=> !pwr_reg[`IPM_BIT_PDOWN]) // RQ10
        else $error("power-down set with watchdog enabled");
    chk_wle_clear: assert property (@(posedge ref_clk) disable iff (rst)
        watchdog_loaded |=> !pwr_reg[`IPM_BIT_WDLOAD]) // RQ9
        else $error("load enable not cleared by load");
    chk_high_first: assert property (@(posedge ref_clk) disable iff (rst)
        (mc_tick && hi_hit) |=> (irq_vector == `IPM_VEC_BASE
        + {9'h000, $past(hi_src), 3'b000})) // RQ23 RQ26
        else $error("high request not served first");
    chk_no_preempt: assert property (@(posedge ref_clk) disable iff (rst)
        (active_reg[1] && mc_tick) |=> !irq_valid) // RQ23
        else $error("high handler pre-empted");
    chk_reti_clear: assert property (@(posedge ref_clk) disable iff (rst)
        (reti && !(ack && irq_valid) && active_reg == 2'b01)
        |=> active_reg == 2'b00) // RQ24
        else $error("return left level active");
    chk_pd_halts: assert property (@(posedge ref_clk) disable iff (rst)
        (mode_reg == IPM_PDOWN) |=> (!sysclk_run && !strobe_level)) // RQ13
        else $error("clock or strobes not low in power-down");
    chk_idle_pins: assert property (@(posedge ref_clk) disable iff (rst)
        (mode_reg == IPM_IDLE) |=> (strobe_level && pwm_force_high
        && twowire_pins_allow == $past(twowire_port_enable))) // RQ15
        else $error("idle pin state wrong");
    chk_wd_restart: assert property (@(posedge ref_clk) disable iff (rst)
        watchdog_reset |-> ##[24:40] cpu_restart) // RQ19
        else $error("no restart after watchdog reset");
    chk_wake_idle: assert property (@(posedge ref_clk) disable iff (rst)
        (mode_reg == IPM_PDOWN && wake_any && wake_blocked)
        |=> mode_reg == IPM_IDLE) // RQ22
        else $error("blocked wake did not enter idle");
endmodule

// [testbench/ipm_cpu_model.sv]
`timescale 1ns/1ps
// cpu sequencer stand-in: takes a vector or returns on command
module ipm_cpu_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic take,
    input wire logic give_back,
    input wire logic irq_valid,
    input wire logic [15:0] irq_vector,
    output logic ack,
    output logic reti,
    output logic [15:0] taken_vector
);
    // ack only while a vector stands, one pulse per command
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack <= 1'h0;
            taken_vector <= 16'h0000;
        end else begin
            ack <= take && irq_valid && !ack;
            if (take && irq_valid && !ack) begin
                taken_vector <= irq_vector;
            end
        end
    end
    // single pulse: a held level would unwind two levels
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reti <= 1'h0;
        end else begin
            reti <= give_back && !reti;
        end
    end
endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
`include "ipm_cfg.svh"
`define CHK(g, e) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        errors++; \
        $display("wrong value at %0t: got %h expected %h", $time, g, e); \
    end \
end
module tb;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic sfr_wr = 1'h0, sfr_rd = 1'h0, global_enable = 1'h0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rv;
    logic [14:0] irq_flags = 15'h0000, irq_enables = 15'h0000, m;
    logic seconds_flag = 1'h0, seconds_irq_enable = 1'h0;
    logic ext_b_level_mode = 1'h0, ext_a_level_mode = 1'h0;
    logic watchdog_loaded = 1'h0, watchdog_reset = 1'h0;
    logic watchdog_enable_input_n = 1'h1, oscillator_source_select = 1'h1;
    logic keep_slow_osc_running = 1'h0, twowire_port_enable = 1'h0;
    logic ext_memory = 1'h0, take = 1'h0, give_back = 1'h0;
    logic ack, reti, irq_valid, baud_double_bit, aux_memory_disable;
    logic [15:0] irq_vector, taken_vector;
    logic latch_toggle_enable, watchdog_load_enable, cpu_halt, sysclk_run;
    logic slow_osc_run, idle_block_reset, strobe_level, strobe_override;
    logic port0_float, port2_addr_drive, twowire_pins_allow;
    logic pwm_force_high, cpu_restart;
    int errors = 0;
    int samples_checked = 0;
    int n;
    logic [3:0] order [15] = '{4'h0, 4'h5, 4'ha, 4'h1, 4'h6, 4'hb, 4'h2,
        4'h7, 4'hc, 4'h3, 4'h8, 4'hd, 4'h4, 4'h9, 4'he};

    ipm_core i_ipm_core (.ref_clk(ref_clk), .rst(rst), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .irq_flags(irq_flags),
        .irq_enables(irq_enables), .global_enable(global_enable),
        .seconds_flag(seconds_flag), .seconds_irq_enable(seconds_irq_enable),
        .ext_b_level_mode(ext_b_level_mode),
        .ext_a_level_mode(ext_a_level_mode), .ack(ack), .reti(reti),
        .watchdog_loaded(watchdog_loaded), .watchdog_reset(watchdog_reset),
        .watchdog_enable_input_n(watchdog_enable_input_n),
        .oscillator_source_select(oscillator_source_select),
        .keep_slow_osc_running(keep_slow_osc_running),
        .twowire_port_enable(twowire_port_enable), .ext_memory(ext_memory),
        .irq_valid(irq_valid), .irq_vector(irq_vector),
        .baud_double_bit(baud_double_bit),
        .aux_memory_disable(aux_memory_disable),
        .latch_toggle_enable(latch_toggle_enable),
        .watchdog_load_enable(watchdog_load_enable), .cpu_halt(cpu_halt),
        .sysclk_run(sysclk_run), .slow_osc_run(slow_osc_run),
        .idle_block_reset(idle_block_reset), .strobe_level(strobe_level),
        .strobe_override(strobe_override), .port0_float(port0_float),
        .port2_addr_drive(port2_addr_drive),
        .twowire_pins_allow(twowire_pins_allow),
        .pwm_force_high(pwm_force_high), .cpu_restart(cpu_restart));
    ipm_cpu_model i_ipm_cpu_model (.ref_clk(ref_clk), .rst(rst),
        .take(take), .give_back(give_back), .irq_valid(irq_valid),
        .irq_vector(irq_vector), .ack(ack), .reti(reti),
        .taken_vector(taken_vector));

    always #25 ref_clk = ~ref_clk;

    task automatic step(input int c);
        repeat (c) @(posedge ref_clk);
        #2;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step(1);
        sfr_wr = 1'h1;
        sfr_addr = a;
        sfr_wdata = d;
        step(1);
        sfr_wr = 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        step(1);
        sfr_rd = 1'h1;
        sfr_addr = a;
        step(1);
        sfr_rd = 1'h0;
        rv = sfr_rdata;
    endtask
    // 30 clocks spans two and a half machine cycles, so the poll has settled
    task automatic irq(input logic [14:0] f, input logic [14:0] e);
        irq_flags = f;
        irq_enables = e;
        step(30);
    endtask
    task automatic take_vec;
        take = 1'h1;
        n = 0;
        while (ack !== 1'h1 && n < 40) begin
            step(1);
            n++;
        end
        `CHK(ack, 1'h1)
        take = 1'h0;
        step(1);
    endtask
    task automatic give;
        give_back = 1'h1;
        step(1);
        give_back = 1'h0;
        step(3);
    endtask
    function automatic logic [15:0] vec(input int k);
        return `IPM_VEC_BASE + `IPM_VEC_STEP * 16'(k);
    endfunction
    task automatic results;
        $display("checked %0d, wrong %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        step(8000);
        errors++;
        results();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        #2;
        rst = 1'h0;
        `CHK(latch_toggle_enable, 1'h1)
        rd(`IPM_ADDR_PWR);
        `CHK(rv, `IPM_PWR_RESET)
        rd(8'h55);
        `CHK(rv, 8'h00)
        $display("test reset done");
        wr(`IPM_ADDR_PWR, 8'hf0);
        step(2);
        `CHK({baud_double_bit, aux_memory_disable}, 2'h3)
        `CHK({latch_toggle_enable, watchdog_load_enable}, 2'h1)
        watchdog_loaded = 1'h1;
        step(1);
        watchdog_loaded = 1'h0;
        step(2);
        rd(`IPM_ADDR_PWR);
        `CHK(rv, 8'he0)
        wr(`IPM_ADDR_LVLA, 8'hff);
        rd(`IPM_ADDR_LVLA);
        `CHK(rv, 8'h7f)
        wr(`IPM_ADDR_LVLB, 8'hff);
        rd(`IPM_ADDR_LVLB);
        `CHK(rv, 8'hff)
        wr(`IPM_ADDR_LVLA, 8'h00);
        wr(`IPM_ADDR_LVLB, 8'h00);
        wr(`IPM_ADDR_PWR, 8'h00);
        $display("test registers done");
        global_enable = 1'h1;
        for (int i = 0; i < 15; i++) begin
            irq(15'h0001 << i, 15'h0001 << i);
            `CHK(irq_vector, vec(i))
        end
        irq(15'h7fff, 15'h0000);
        `CHK(irq_valid, 1'h0)
        for (int i = 0; i < 15; i++) begin
            m = 15'h0000;
            for (int j = i; j < 15; j++) begin
                m[order[j]] = 1'h1;
            end
            irq(m, 15'h7fff);
            `CHK(irq_vector, vec(order[i]))
        end
        $display("test vectors done");
        wr(`IPM_ADDR_LVLB, 8'h80);
        irq(15'h7fff, 15'h7fff);
        `CHK(irq_vector, 16'h0073)
        take_vec();
        step(30);
        `CHK(irq_valid, 1'h0)
        give();
        step(30);
        `CHK(irq_valid, 1'h1)
        wr(`IPM_ADDR_LVLB, 8'h00);
        step(30);
        take_vec();
        `CHK(taken_vector, 16'h0003)
        wr(`IPM_ADDR_LVLA, 8'h02);
        step(30);
        `CHK(irq_vector, 16'h000b)
        take_vec();
        give();
        give();
        wr(`IPM_ADDR_LVLA, 8'h00);
        seconds_flag = 1'h1;
        seconds_irq_enable = 1'h1;
        irq(15'h0000, 15'h0004);
        `CHK(irq_vector, 16'h0013)
        seconds_irq_enable = 1'h0;
        irq(15'h0000, 15'h0004);
        `CHK(irq_valid, 1'h0)
        seconds_flag = 1'h0;
        $display("test levels done");
        ext_memory = 1'h1;
        wr(`IPM_ADDR_PWR, 8'h01);
        step(3);
        `CHK({cpu_halt, idle_block_reset, pwm_force_high}, 3'h7)
        `CHK({strobe_level, port0_float, port2_addr_drive}, 3'h7)
        `CHK(strobe_override, 1'h1)
        `CHK(twowire_pins_allow, 1'h0)
        twowire_port_enable = 1'h1;
        step(2);
        `CHK(twowire_pins_allow, 1'h1)
        irq(15'h0400, 15'h0400);
        `CHK(cpu_halt, 1'h1)
        irq(15'h0002, 15'h0002);
        `CHK(cpu_halt, 1'h0)
        rd(`IPM_ADDR_PWR);
        `CHK(rv, 8'h00)
        irq(15'h0000, 15'h0000);
        wr(`IPM_ADDR_PWR, 8'h01);
        step(3);
        watchdog_reset = 1'h1;
        step(1);
        watchdog_reset = 1'h0;
        n = 1;
        while (cpu_restart !== 1'h1 && n < 60) begin
            step(1);
            n++;
        end
        `CHK(n - 1 >= 25 && n - 1 <= 36, 1'h1)
        `CHK(cpu_halt, 1'h0)
        wr(`IPM_ADDR_PWR, 8'h01);
        step(3);
        `CHK(cpu_halt, 1'h1)
        rst = 1'h1;
        step(24);
        rst = 1'h0;
        `CHK(cpu_halt, 1'h0)
        $display("test idle done");
        watchdog_enable_input_n = 1'h0;
        wr(`IPM_ADDR_PWR, 8'h02);
        rd(`IPM_ADDR_PWR);
        `CHK(rv, 8'h00)
        watchdog_enable_input_n = 1'h1;
        oscillator_source_select = 1'h0;
        keep_slow_osc_running = 1'h1;
        wr(`IPM_ADDR_PWR, 8'h02);
        step(2);
        `CHK({sysclk_run, slow_osc_run}, 2'h1)
        `CHK({strobe_level, twowire_pins_allow, pwm_force_high}, 3'h1)
        rd(`IPM_ADDR_PWR);
        `CHK(rv, 8'h02)
        ext_a_level_mode = 1'h1;
        global_enable = 1'h1;
        irq(15'h0001, 15'h0001);
        `CHK(sysclk_run, 1'h1)
        take_vec();
        irq(15'h0000, 15'h0001);
        wr(`IPM_ADDR_PWR, 8'h02);
        step(3);
        irq(15'h0001, 15'h0001);
        `CHK({sysclk_run, cpu_halt}, 2'h3)
        give();
        $display("test power-down done");
        results();
    end
endmodule
